/* File: bench/scd_media_model.sv */
// Media side model taking block writes from the format walk.
// Assumes writes come in ascending block order from zero.
module scd_media_model #(
    parameter logic [15:0] BLOCKS = 16'h0010
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic media_wr,
    input wire logic [15:0] media_addr,
    input wire logic [7:0] media_data,
    output int writes,
    output int errs
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [15:0] exp_addr = 16'(writes % BLOCKS);
    // Each user block gets the fill pattern, in order
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            writes <= 0;
            errs <= 0;
        end else if (media_wr === 1'b1) begin
            writes <= writes + 1;
            if (media_data !== 8'h00 || media_addr !== exp_addr) begin
                errs <= errs + 1;
            end
        end
    end
endmodule : scd_media_model

/* File: bench/tb_scsi_command_decoder.sv */
// Bench of the command decoder: APB master, opcode, link and format runs.
// Assumes scd_pkg, the design and the media model are compiled first.
module tb_scsi_command_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Harness
    // ****
    localparam logic [15:0] BLKS = 16'h0010;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, media_data;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, media_wr, e;
    logic [15:0] media_addr, ilv;
    logic [2:0] lun;
    int bad_count = 0, check_count = 0, cyc = 0, writes, errs, w0;
    integer seed = 32'h2449_2952;
    logic [7:0] ops [6] = '{8'h00, 8'h12, 8'h28, 8'h2A, 8'h0A, 8'h04};
    logic [2:0] dlfs [3] = '{3'h0, 3'h4, 3'h5};
    logic [47:0] bad [4] = '{48'hFF00_0000_0001, 48'h0000_0000_0081,
        48'h0401_0000_0000, 48'h0400_0100_0000};
    scd_top #(.USER_BLOCKS(BLKS)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .media_wr, .media_addr, .media_data);
    scd_media_model #(.BLOCKS(BLKS)) media_u (.pclk, .presetn, .media_wr, .media_addr,
        .media_data, .writes, .errs);
    `define CHK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin bad_count++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Stops on done, or on the wait for defect data
    task automatic poll();
        do apb(1'b0, scd_pkg::OFS_STAT, 32'h0000_0000); while (q[30] !== 1'b1 && q[29] !== 1'b1);
    endtask : poll
    task automatic run(input logic [47:0] c);
        apb(1'b1, scd_pkg::OFS_CDB0, c[47:16]);
        apb(1'b1, scd_pkg::OFS_CDB1, {c[15:0], 16'h0000});
        apb(1'b1, scd_pkg::OFS_CDB2, 32'h0000_0000);
        apb(1'b1, scd_pkg::OFS_CTRL, 32'h0000_0001);
        poll();
    endtask : run
    task automatic fmt(input logic [2:0] f, input logic [7:0] n, input logic [15:0] len,
        input logic im);
        run({8'h04, 5'h03, f, 32'h0000_0000});
        `CHK("wait", 1'b1, q[29])
        apb(1'b1, scd_pkg::OFS_DLHDR, {14'h0000, im, 1'b0, len});
        apb(1'b1, scd_pkg::OFS_DLCNT, {24'h00_0000, n});
        apb(1'b1, scd_pkg::OFS_CTRL, 32'h0000_0002);
        poll();
    endtask : fmt
    function automatic logic [15:0] link_exp(input logic [1:0] c);
        if (c == 2'h2) return 16'h0200;
        return c[0] ? {8'h10, 7'h05, c[1]} : 16'h0000;
    endfunction : link_exp
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ops[i]) begin
            lun = 3'($random(seed));
            w0 = writes;
            run({ops[i], ((ops[i] == 8'h04) ? 8'h00 : {lun, 5'h00}), 32'h0000_0000});
            `CHK("op", 8'h00, q[23:16])
            `CHK("lun", ((ops[i] == 8'h04) ? 3'h0 : lun), q[26:24])
            `CHK("nowait", 1'b0, q[29])
        end
        `CHK("blocks", BLKS, 16'(writes - w0))
        $display("opcodes done");
        foreach (bad[i]) begin
            run(bad[i]);
            `CHK("fail", 16'h0200, q[23:8])
            apb(1'b0, scd_pkg::OFS_SENSE, 32'h0000_0000);
            `CHK("sense", ((i == 0) ? 12'h520 : 12'h524), q[11:0])
        end
        $display("failures done");
        for (int c = 0; c < 4; c++) begin
            run({40'h00_0000_0000, 8'(c)});
            `CHK("link", link_exp(2'(c)), q[23:8])
        end
        $display("link done");
        for (int k = 0; k < 3; k++) begin
            ilv = (k < 2) ? 16'(k) : (16'($random(seed)) | 16'h0002);
            run({24'h04_0000, ilv, 8'h00});
            `CHK("ilv", 8'h00, q[23:16])
            `CHK("ilv eff", 8'h01, q[7:0])
        end
        $display("interleave done");
        for (int k = 0; k < 3; k++) begin
            w0 = ($random(seed) & 3) + 1;
            fmt(dlfs[k], 8'(w0), 16'(w0 * ((k == 0) ? 4 : 8)), 1'b0);
            `CHK("fmt", 8'h00, q[23:16])
            apb(1'b0, scd_pkg::OFS_LISTS, 32'h0000_0000);
            `CHK("lists", {8'h10, 8'(w0), 8'(w0)}, q[23:0])
        end
        // Reassignment adds one grown defect while idle
        apb(1'b1, scd_pkg::OFS_CTRL, 32'h0000_0004);
        apb(1'b0, scd_pkg::OFS_LISTS, 32'h0000_0000);
        `CHK("grow", {8'h10, 8'(w0 + 1), 8'(w0)}, q[23:0])
        // Immediate: good status while the walk is still busy
        fmt(3'h4, 8'h01, 16'h0008, 1'b1);
        `CHK("immed", {3'b110, 8'h00}, {q[31:29], q[23:16]})
        do apb(1'b0, scd_pkg::OFS_STAT, 32'h0000_0000); while (q[31] !== 1'b0);
        apb(1'b0, scd_pkg::OFS_SENSE, 32'h0000_0000);
        `CHK("deferred", 13'h0000, {q[16], q[11:0]})
        fmt(3'h0, 8'h80, 16'h0200, 1'b0);
        apb(1'b0, scd_pkg::OFS_SENSE, 32'h0000_0000);
        `CHK("count", 12'h526, q[11:0])
        fmt(3'h0, 8'h02, 16'h0009, 1'b0);
        apb(1'b0, scd_pkg::OFS_SENSE, 32'h0000_0000);
        `CHK("len", 12'h526, q[11:0])
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK("slverr", 1'b1, e)
        `CHK("media", 0, errs)
        $display("format done");
        final_report();
    end
endmodule : tb_scsi_command_decoder

/* File: logic/scd_dec.sv */
// Combinational field decoder of a twelve-byte command block.
// Assumes byte 0 sits in the top bits of cdb.
module scd_dec (
    input wire logic [95:0] cdb,
    output logic supported,
    output logic is_format,
    output logic ctrl_bad,
    output logic link,
    output logic flag,
    output logic [2:0] lun,
    output logic fmt_bad,
    output logic data_follows_bit,
    output logic list_replace_bit,
    output logic [2:0] dlf,
    output logic [15:0] ilv_eff
);
    wire [7:0] op = cdb[95:88];
    wire [7:0] b1 = cdb[87:80];
    wire [7:0] b2 = cdb[79:72];
    wire [15:0] ilv = cdb[71:56];
    wire [3:0] cidx = scd_pkg::ctrl_index(op);
    wire [7:0] ctrl = cdb[8'(95 - 8 * cidx) -: 8];
    wire dlf_ok = (dlf == scd_pkg::DLF_BLOCK) || (dlf == scd_pkg::DLF_INDEX)
        || (dlf == scd_pkg::DLF_PHYS);

    assign supported = scd_pkg::op_supported(op);
    assign is_format = (op == scd_pkg::OP_FORMAT);
    assign link = ctrl[0];
    assign flag = ctrl[1];
    assign ctrl_bad = (ctrl[7:2] != 6'h00) || (flag && !link);
    assign lun = b1[7:5];
    assign data_follows_bit = b1[4];
    assign list_replace_bit = b1[3];
    assign dlf = b1[2:0];
    // Other interleave values are harmless: buffering hides them
    assign ilv_eff = (ilv > scd_pkg::ILV_ONE) ? scd_pkg::ILV_ONE : scd_pkg::ILV_ONE;
    assign fmt_bad = (b1[7:5] != 3'b000) || (b2 != 8'h00)
        || (!data_follows_bit && dlf != scd_pkg::DLF_BLOCK)
        || (data_follows_bit && !dlf_ok);
endmodule : scd_dec

/* File: logic/scd_fmt_eng.sv */
// Format engine: walks the user area writing the fill pattern.
// Assumes start is a one-cycle pulse while idle.
module scd_fmt_eng #(
    parameter logic [15:0] USER_BLOCKS = 16'h0400
) (
    input wire logic pclk,
    input wire logic presetn,
    scd_fmt_if.eng f
);
    logic run_r;
    logic [15:0] addr_r;
    logic wr_r;
    logic done_r;
    logic err_r;
    logic [7:0] grown_r;
    wire [9:0] total = 10'(scd_pkg::FACTORY_CNT) + 10'(f.grown) + 10'(f.supplied);
    wire last = (addr_r == USER_BLOCKS - 16'h0001);

    assign f.busy = run_r;
    assign f.done = done_r;
    assign f.err = err_r;
    assign f.grown_new = grown_r;
    assign f.wr_en = wr_r;
    assign f.addr = addr_r;
    assign f.data = scd_pkg::FILL_PATTERN;

    // Addresses stop at the user area, reserved blocks are never written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
            addr_r <= 16'h0000;
            wr_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            grown_r <= 8'h00;
        end else begin
            done_r <= 1'b0;
            if (f.start && !run_r) begin
                run_r <= 1'b1;
                wr_r <= 1'b1;
                addr_r <= 16'h0000;
                err_r <= (total > 10'(scd_pkg::SPARE_CNT));
                grown_r <= f.replace ? f.supplied : 8'(10'(f.grown) + 10'(f.supplied));
            end else if (run_r) begin
                addr_r <= last ? addr_r : addr_r + 16'h0001;
                wr_r <= !last;
                run_r <= !last;
                done_r <= last;
            end
        end
    end
endmodule : scd_fmt_eng

/* File: logic/scd_fmt_if.sv */
// Link between the command sequencer and the format engine.
// Assumes both ends share pclk.
interface scd_fmt_if;
    logic start;
    logic replace;
    logic [7:0] supplied;
    logic [7:0] grown;
    logic busy;
    logic done;
    logic err;
    logic [7:0] grown_new;
    logic wr_en;
    logic [15:0] addr;
    logic [7:0] data;
    modport ctl(output start, replace, supplied, grown,
        input busy, done, err, grown_new, wr_en, addr, data);
    modport eng(input start, replace, supplied, grown,
        output busy, done, err, grown_new, wr_en, addr, data);
endinterface : scd_fmt_if

/* File: logic/scd_pkg.sv */
// Constants, types and opcode table of the command block decoder.
// Assumes one 40 MHz APB clock and software that loads each block before starting it.
package scd_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CDB0 = 8'h04;
    localparam logic [7:0] OFS_CDB1 = 8'h08;
    localparam logic [7:0] OFS_CDB2 = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_SENSE = 8'h14;
    localparam logic [7:0] OFS_DLHDR = 8'h18;
    localparam logic [7:0] OFS_DLCNT = 8'h1C;
    localparam logic [7:0] OFS_LISTS = 8'h20;
    localparam int CTRL_START = 0;
    localparam int CTRL_DDONE = 1;
    localparam int CTRL_GROW = 2;
    // ****************************************
    // Status, message and sense codes
    // ****************************************
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [7:0] ST_INTER_GOOD = 8'h10;
    localparam logic [7:0] MSG_CMD_DONE = 8'h00;
    localparam logic [7:0] MSG_LINKED = 8'h0A;
    localparam logic [7:0] MSG_LINKED_FLAG = 8'h0B;
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_MEDIUM = 4'h3;
    localparam logic [3:0] KEY_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_BAD_OP = 8'h20;
    localparam logic [7:0] ASC_BAD_CDB = 8'h24;
    localparam logic [7:0] ASC_BAD_PARAM = 8'h26;
    localparam logic [7:0] ASC_DEFECT_ERR = 8'h19;
    // ****************************************
    // Command block layout
    // ****************************************
    localparam logic [7:0] OP_FORMAT = 8'h04;
    localparam logic [2:0] DLF_BLOCK = 3'b000;
    localparam logic [2:0] DLF_INDEX = 3'b100;
    localparam logic [2:0] DLF_PHYS = 3'b101;
    localparam logic [15:0] ILV_ONE = 16'h0001;
    localparam logic [7:0] MAX_DESC = 8'h80;
    localparam logic [7:0] FILL_PATTERN = 8'h00;
    localparam logic [7:0] FACTORY_CNT = 8'h10;
    localparam logic [7:0] SPARE_CNT = 8'hC0;
    localparam int BLK_W = 16;

    typedef enum logic [2:0] {
        S_IDLE, S_DECODE, S_DATA, S_LIST, S_FMT, S_END
    } scd_state_t;

    // Supported operation codes
    function automatic logic op_supported(input logic [7:0] op);
        unique case (op)
            8'h00, 8'h01, 8'h03, 8'h04, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h12, 8'h15,
            8'h16, 8'h17, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h25, 8'h28, 8'h2A, 8'h2B,
            8'h2E, 8'h2F, 8'h34, 8'h35, 8'h37, 8'h3B, 8'h3C, 8'h3E, 8'h3F, 8'h41,
            8'h4C, 8'h4D, 8'h55, 8'h56, 8'h57, 8'h5A, 8'h5E, 8'h5F, 8'hA0,
            8'hB7: op_supported = 1'b1;
            default: op_supported = 1'b0;
        endcase
    endfunction : op_supported

    // Index of the control byte from the opcode group
    function automatic logic [3:0] ctrl_index(input logic [7:0] op);
        unique case (op[7:5])
            3'd1, 3'd2: ctrl_index = 4'd9;
            3'd5: ctrl_index = 4'd11;
            default: ctrl_index = 4'd5;
        endcase
    endfunction : ctrl_index
endpackage : scd_pkg

/* File: logic/scd_top.sv */
// Command block decoder with APB register access and format sequencing.
// Assumes an APB master on pclk; media_wr and media_addr are registered, media_data is the constant FILL_PATTERN.
//
// Design decisions made here: the APB register port and the register offsets.
module scd_top #(
    parameter logic [15:0] USER_BLOCKS = 16'h0400
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic media_wr,
    output logic [15:0] media_addr,
    output logic [7:0] media_data
);
    // ****************************************
    // APB slave
    // ****************************************
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] cdb0_r, cdb1_r, cdb2_r, dlhdr_r;
    logic [7:0] dlcnt_r;
    wire acc = psel && penable;
    wire wr_done = acc && pready_r && pwrite;
    wire sel_ctrl = (paddr == scd_pkg::OFS_CTRL);
    wire sel_cdb0 = (paddr == scd_pkg::OFS_CDB0);
    wire sel_cdb1 = (paddr == scd_pkg::OFS_CDB1);
    wire sel_cdb2 = (paddr == scd_pkg::OFS_CDB2);
    wire sel_stat = (paddr == scd_pkg::OFS_STAT);
    wire sel_sense = (paddr == scd_pkg::OFS_SENSE);
    wire sel_hdr = (paddr == scd_pkg::OFS_DLHDR);
    wire sel_cnt = (paddr == scd_pkg::OFS_DLCNT);
    wire sel_lists = (paddr == scd_pkg::OFS_LISTS);
    wire mapped = sel_ctrl | sel_cdb0 | sel_cdb1 | sel_cdb2 | sel_stat | sel_sense
        | sel_hdr | sel_cnt | sel_lists;
    wire wr_start = wr_done && sel_ctrl && pwdata[scd_pkg::CTRL_START];
    wire wr_ddone = wr_done && sel_ctrl && pwdata[scd_pkg::CTRL_DDONE];
    wire wr_grow = wr_done && sel_ctrl && pwdata[scd_pkg::CTRL_GROW];

    // ****************************************
    // Sequencer state
    // ****************************************
    scd_pkg::scd_state_t st_r;
    logic busy_r, done_r, wait_r, defer_r, immed_r;
    logic [7:0] status_r, msg_r, asc_r, grown_r, supplied_r;
    logic [3:0] key_r;
    logic [2:0] lun_r;
    logic [15:0] ilv_r;
    logic fstart_r;
    logic [31:0] rd_mux;

    wire supported, is_format, ctrl_bad, link, flag, fmt_bad;
    wire dfollow, lreplace;
    wire [2:0] lun, dlf;
    wire [15:0] ilv_eff;
    scd_fmt_if fif();

    scd_dec u_dec (
        .cdb({cdb0_r, cdb1_r, cdb2_r}),
        .supported(supported),
        .is_format(is_format),
        .ctrl_bad(ctrl_bad),
        .link(link),
        .flag(flag),
        .lun(lun),
        .fmt_bad(fmt_bad),
        .data_follows_bit(dfollow),
        .list_replace_bit(lreplace),
        .dlf(dlf),
        .ilv_eff(ilv_eff)
    );

    scd_fmt_eng #(.USER_BLOCKS(USER_BLOCKS)) u_eng (
        .pclk(pclk),
        .presetn(presetn),
        .f(fif.eng)
    );

    // Defect header: byte 1 bit 1 immediate, bytes 2..3 list length
    wire hdr_immed = dlhdr_r[17];
    wire [15:0] dl_len = dlhdr_r[15:0];
    wire [15:0] len_blk = {6'h00, dlcnt_r, 2'b00};
    wire [15:0] len_other = {5'h00, dlcnt_r, 3'b000};
    wire len_ok = (dlf == scd_pkg::DLF_BLOCK) ? (dl_len == len_blk) : (dl_len == len_other);
    wire list_ok = (dlcnt_r < scd_pkg::MAX_DESC) && len_ok && !(hdr_immed && link);
    wire [7:0] good_st = link ? scd_pkg::ST_INTER_GOOD : scd_pkg::ST_GOOD;
    wire [7:0] good_msg = !link ? scd_pkg::MSG_CMD_DONE
        : (flag ? scd_pkg::MSG_LINKED_FLAG : scd_pkg::MSG_LINKED);

    assign fif.start = fstart_r;
    assign fif.replace = lreplace;
    assign fif.supplied = supplied_r;
    assign fif.grown = grown_r;

    assign rd_mux = sel_cdb0 ? cdb0_r : sel_cdb1 ? cdb1_r : sel_cdb2 ? cdb2_r
        : sel_stat ? {busy_r, done_r, wait_r, 2'b00, lun_r, status_r, msg_r, ilv_r[7:0]}
        : sel_sense ? {15'h0000, defer_r, 4'h0, key_r, asc_r}
        : sel_hdr ? dlhdr_r : sel_cnt ? {24'h00_0000, dlcnt_r}
        : sel_lists ? {8'h00, scd_pkg::FACTORY_CNT, grown_r, supplied_r} : 32'h0000_0000;

    // One wait state: answer registered at the first access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc && !pready_r;
            pslverr_r <= acc && !pready_r && !mapped;
            prdata_r <= (acc && !pready_r && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdb0_r <= 32'h0000_0000;
            cdb1_r <= 32'h0000_0000;
            cdb2_r <= 32'h0000_0000;
            dlhdr_r <= 32'h0000_0000;
            dlcnt_r <= 8'h00;
        end else if (wr_done && !busy_r) begin
            if (sel_cdb0) cdb0_r <= pwdata;
            if (sel_cdb1) cdb1_r <= pwdata;
            if (sel_cdb2) cdb2_r <= pwdata;
        end else if (wr_done && wait_r) begin
            if (sel_hdr) dlhdr_r <= pwdata;
            if (sel_cnt) dlcnt_r <= pwdata[7:0];
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= scd_pkg::S_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            wait_r <= 1'b0;
            defer_r <= 1'b0;
            immed_r <= 1'b0;
            status_r <= scd_pkg::ST_GOOD;
            msg_r <= scd_pkg::MSG_CMD_DONE;
            key_r <= scd_pkg::KEY_NONE;
            asc_r <= scd_pkg::ASC_NONE;
            lun_r <= 3'b000;
            ilv_r <= scd_pkg::ILV_ONE;
            grown_r <= 8'h00;
            supplied_r <= 8'h00;
            fstart_r <= 1'b0;
        end else begin
            fstart_r <= 1'b0;
            // Reassignment grows the list only while no format owns it
            if (wr_grow && !busy_r && grown_r != 8'hFF) grown_r <= grown_r + 8'h01;
            unique case (st_r)
                scd_pkg::S_IDLE: if (wr_start) begin
                    busy_r <= 1'b1;
                    done_r <= 1'b0;
                    immed_r <= 1'b0;
                    st_r <= scd_pkg::S_DECODE;
                end
                scd_pkg::S_DECODE: begin
                    lun_r <= lun;
                    ilv_r <= ilv_eff;
                    key_r <= scd_pkg::KEY_ILLEGAL;
                    if (!supported) begin
                        asc_r <= scd_pkg::ASC_BAD_OP;
                        st_r <= scd_pkg::S_END;
                    end else if (ctrl_bad || (is_format && fmt_bad)) begin
                        asc_r <= scd_pkg::ASC_BAD_CDB;
                        st_r <= scd_pkg::S_END;
                    end else if (is_format && dfollow) begin
                        wait_r <= 1'b1;
                        st_r <= scd_pkg::S_DATA;
                    end else if (is_format) begin
                        supplied_r <= 8'h00;
                        fstart_r <= 1'b1;
                        st_r <= scd_pkg::S_FMT;
                    end else begin
                        key_r <= scd_pkg::KEY_NONE;
                        asc_r <= scd_pkg::ASC_NONE;
                        st_r <= scd_pkg::S_END;
                    end
                end
                scd_pkg::S_DATA: if (wr_ddone) begin
                    wait_r <= 1'b0;
                    st_r <= scd_pkg::S_LIST;
                end
                scd_pkg::S_LIST: if (!list_ok) begin
                    asc_r <= scd_pkg::ASC_BAD_PARAM;
                    st_r <= scd_pkg::S_END;
                end else begin
                    supplied_r <= dlcnt_r;
                    fstart_r <= 1'b1;
                    immed_r <= hdr_immed;
                    if (hdr_immed) begin
                        done_r <= 1'b1;
                        status_r <= good_st;
                        msg_r <= good_msg;
                        key_r <= scd_pkg::KEY_NONE;
                        asc_r <= scd_pkg::ASC_NONE;
                    end
                    st_r <= scd_pkg::S_FMT;
                end
                scd_pkg::S_FMT: if (fif.done) begin
                    grown_r <= fif.grown_new;
                    key_r <= fif.err ? scd_pkg::KEY_MEDIUM : scd_pkg::KEY_NONE;
                    asc_r <= fif.err ? scd_pkg::ASC_DEFECT_ERR : scd_pkg::ASC_NONE;
                    defer_r <= fif.err && immed_r;
                    st_r <= immed_r ? scd_pkg::S_IDLE : scd_pkg::S_END;
                    busy_r <= !immed_r;
                end
                scd_pkg::S_END: begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    status_r <= (key_r == scd_pkg::KEY_NONE) ? good_st : scd_pkg::ST_CHECK;
                    msg_r <= (key_r == scd_pkg::KEY_NONE) ? good_msg : scd_pkg::MSG_CMD_DONE;
                    st_r <= scd_pkg::S_IDLE;
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign media_wr = fif.wr_en;
    assign media_addr = fif.addr;
    assign media_data = fif.data;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_unsup;
        st_r == scd_pkg::S_DECODE && !supported |=> ##1 status_r == scd_pkg::ST_CHECK
            && asc_r == scd_pkg::ASC_BAD_OP && !fstart_r;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported opcode not rejected");
    property p_link_ok;
        st_r == scd_pkg::S_END && key_r == scd_pkg::KEY_NONE && link && !flag
            |=> status_r == scd_pkg::ST_INTER_GOOD && msg_r == scd_pkg::MSG_LINKED;
    endproperty
    a_link_ok: assert property (p_link_ok) else $error("linked success reply wrong");
    property p_fail_msg;
        st_r == scd_pkg::S_END && key_r != scd_pkg::KEY_NONE
            |=> status_r == scd_pkg::ST_CHECK && msg_r == scd_pkg::MSG_CMD_DONE;
    endproperty
    a_fail_msg: assert property (p_fail_msg) else $error("failure reply wrong");
    property p_no_data;
        st_r == scd_pkg::S_DECODE && is_format && !dfollow && dlf != scd_pkg::DLF_BLOCK
            |=> asc_r == scd_pkg::ASC_BAD_CDB && st_r == scd_pkg::S_END;
    endproperty
    a_no_data: assert property (p_no_data) else $error("bad format field accepted");
    property p_wait;
        st_r == scd_pkg::S_DECODE && supported && is_format && dfollow && !ctrl_bad
            && !fmt_bad |=> wait_r throughout (st_r == scd_pkg::S_DATA)[*1];
    endproperty
    a_wait: assert property (p_wait) else $error("data-out not awaited");
    property p_list;
        st_r == scd_pkg::S_LIST && dlcnt_r >= scd_pkg::MAX_DESC
            |=> asc_r == scd_pkg::ASC_BAD_PARAM ##1 status_r == scd_pkg::ST_CHECK;
    endproperty
    a_list: assert property (p_list) else $error("oversize defect list accepted");
    property p_ilv;
        st_r == scd_pkg::S_DECODE |=> ilv_r == scd_pkg::ILV_ONE;
    endproperty
    a_ilv: assert property (p_ilv) else $error("interleave not 1:1");
    property p_replace;
        st_r == scd_pkg::S_FMT && fif.done && lreplace |=> grown_r == supplied_r;
    endproperty
    a_replace: assert property (p_replace) else $error("grown list not replaced");
    property p_immed;
        st_r == scd_pkg::S_LIST && list_ok && hdr_immed
            |=> done_r && busy_r && status_r != scd_pkg::ST_CHECK;
    endproperty
    a_immed: assert property (p_immed) else $error("immediate good missing");
    property p_fill;
        media_wr |-> fif.busy && media_addr < USER_BLOCKS
            && media_data == scd_pkg::FILL_PATTERN;
    endproperty
    a_fill: assert property (p_fill) else $error("write outside user area");

    c_format: cover property (st_r == scd_pkg::S_FMT && fif.done);
    c_linked: cover property (st_r == scd_pkg::S_END && link && key_r == scd_pkg::KEY_NONE);
    c_badop: cover property (st_r == scd_pkg::S_DECODE && !supported);
    c_immed: cover property (defer_r);
endmodule : scd_top
